// *** core/ptp_clock_control.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ptp_clock_defines.vh"

// Functional notes
// - Bit 15 set hides corrections from switch
// - Bit 6 steps clock by held time
// - Bit 5 one adds step, zero subtracts
// - Bit 4 captures clock into time registers
// - Bit 3 loads clock from time registers
// - Bit 2 applies rate every 25MHz tick
// - Bit 1 lets the clock advance
// - Bit 0 resets the clock time state
// - Phase selects one of five 8ns steps
// - Nanoseconds and seconds split in 16-bit words
// - Rate sign one adds, zero subtracts
module ptp_clock_control (
  input wire clock_i,
  input wire rst_n_i,
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  output reg [2:0] rtc_phase_o,
  output reg [31:0] rtc_ns_o,
  output reg [31:0] rtc_sec_o,
  output reg switch_adj_pulse_o,
  output reg switch_adj_up_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg freq_hold;
  reg step_dir;
  reg cont_en;
  reg clock_en;
  reg cmd_step;
  reg cmd_read;
  reg cmd_load;
  reg cmd_reset;
  reg [2:0] t_phase;
  reg [31:0] t_ns;
  reg [31:0] t_sec;
  reg rate_sign_select;
  reg rate_temp;
  reg [29:0] fractional_rate_value;
  reg [29:0] frac_acc;
  wire tick;
  wire wr_ctrl;

  // Commands live one cycle only, so the action happens exactly once per write.
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `TCC_ADDR);

  tick_divider u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  // ****************************************************************
  // Time arithmetic
  // ****************************************************************
  reg [30:0] frac_sum;
  reg adj_event;
  reg ns_carry;
  reg ns_borrow;
  reg [29:0] next_frac;
  reg [32:0] ns_run;
  reg [31:0] next_run_ns;
  reg [31:0] next_run_sec;
  reg [32:0] ns_step;
  reg [31:0] next_step_ns;
  reg [31:0] next_step_sec;

  always @* begin
    // A command that takes the tick also takes the correction, so no pulse is lost or doubled.
    adj_event = tick && clock_en && cont_en && !cmd_reset && !cmd_load && !cmd_step;
    ns_carry = 1'b0;
    ns_borrow = 1'b0;
    next_frac = frac_acc;
    if (rate_sign_select) begin
      frac_sum = {1'b0, frac_acc} + {1'b0, fractional_rate_value};
      ns_carry = adj_event && frac_sum[30];
    end else begin
      frac_sum = {1'b0, frac_acc} - {1'b0, fractional_rate_value};
      ns_borrow = adj_event && frac_sum[30];
    end
    if (adj_event) begin
      next_frac = frac_sum[29:0];
    end
    ns_run = {1'b0, rtc_ns_o} + `NS_PER_TICK + {32'h00000000, ns_carry}
      - {32'h00000000, ns_borrow};
    if (ns_run >= `NS_PER_SEC) begin
      next_run_ns = ns_run[31:0] - `NS_WRAP;
      next_run_sec = rtc_sec_o + 32'h00000001;
    end else begin
      next_run_ns = ns_run[31:0];
      next_run_sec = rtc_sec_o;
    end
    if (step_dir) begin
      ns_step = {1'b0, rtc_ns_o} + {1'b0, t_ns};
      if (ns_step >= `NS_PER_SEC) begin
        next_step_ns = ns_step[31:0] - `NS_WRAP;
        next_step_sec = rtc_sec_o + t_sec + 32'h00000001;
      end else begin
        next_step_ns = ns_step[31:0];
        next_step_sec = rtc_sec_o + t_sec;
      end
    end else begin
      ns_step = {1'b0, rtc_ns_o} - {1'b0, t_ns};
      if (ns_step[32]) begin
        next_step_ns = ns_step[31:0] + `NS_WRAP;
        next_step_sec = rtc_sec_o - t_sec - 32'h00000001;
      end else begin
        next_step_ns = ns_step[31:0];
        next_step_sec = rtc_sec_o - t_sec;
      end
    end
  end

  // ****************************************************************
  // Control register and commands
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_hold <= 1'b0;
      step_dir <= 1'b0;
      cont_en <= 1'b0;
      clock_en <= 1'b0;
      cmd_step <= 1'b0;
      cmd_read <= 1'b0;
      cmd_load <= 1'b0;
      cmd_reset <= 1'b0;
    end else begin
      cmd_step <= wr_ctrl && reg_wdata_i[`TCC_STEP_BIT];
      cmd_read <= wr_ctrl && reg_wdata_i[`TCC_READ_BIT];
      cmd_load <= wr_ctrl && reg_wdata_i[`TCC_LOAD_BIT];
      cmd_reset <= wr_ctrl && reg_wdata_i[`TCC_RESET_BIT];
      if (wr_ctrl) begin
        freq_hold <= reg_wdata_i[`TCC_FREQ_HOLD_BIT];
        step_dir <= reg_wdata_i[`TCC_STEP_DIR_BIT];
        cont_en <= reg_wdata_i[`TCC_CONT_BIT];
        clock_en <= reg_wdata_i[`TCC_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // Time and rate registers
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_phase <= `PHASE_RESET;
      t_ns <= 32'h00000000;
      t_sec <= 32'h00000000;
      rate_sign_select <= 1'b0;
      rate_temp <= 1'b0;
      fractional_rate_value <= 30'h00000000;
    end else if (cmd_read) begin
      t_phase <= rtc_phase_o;
      t_ns <= rtc_ns_o;
      t_sec <= rtc_sec_o;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        // Invalid phase codes are refused so the clock never holds one.
        `PHASE_ADDR: if (reg_wdata_i[2:0] <= `PHASE_MAX) t_phase <= reg_wdata_i[2:0];
        `NS_HI_ADDR: t_ns[31:16] <= reg_wdata_i;
        `NS_LO_ADDR: t_ns[15:0] <= reg_wdata_i;
        `SEC_HI_ADDR: t_sec[31:16] <= reg_wdata_i;
        `SEC_LO_ADDR: t_sec[15:0] <= reg_wdata_i;
        `RATE_HI_ADDR: begin
          rate_sign_select <= reg_wdata_i[`RATE_SIGN_BIT];
          rate_temp <= reg_wdata_i[`RATE_TEMP_BIT];
          fractional_rate_value[29:16] <= reg_wdata_i[`RATE_HI_MSB:0];
        end
        `RATE_LO_ADDR: fractional_rate_value[15:0] <= reg_wdata_i;
        default: t_phase <= t_phase;
      endcase
    end
  end

  // ****************************************************************
  // Running clock
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtc_phase_o <= `PHASE_RESET;
      rtc_ns_o <= 32'h00000000;
      rtc_sec_o <= 32'h00000000;
      frac_acc <= 30'h00000000;
      switch_adj_pulse_o <= 1'b0;
      switch_adj_up_o <= 1'b0;
    end else begin
      // Corrections reach the switch only while it is allowed to follow them.
      switch_adj_pulse_o <= adj_event && (ns_carry || ns_borrow) && !freq_hold;
      switch_adj_up_o <= rate_sign_select;
      if (cmd_reset) begin
        rtc_phase_o <= `PHASE_RESET;
        rtc_ns_o <= 32'h00000000;
        rtc_sec_o <= 32'h00000000;
        frac_acc <= 30'h00000000;
      end else if (cmd_load) begin
        rtc_phase_o <= t_phase;
        rtc_ns_o <= t_ns;
        rtc_sec_o <= t_sec;
      end else if (cmd_step) begin
        rtc_ns_o <= next_step_ns;
        rtc_sec_o <= next_step_sec;
      end else if (tick && clock_en) begin
        rtc_ns_o <= next_run_ns;
        rtc_sec_o <= next_run_sec;
        frac_acc <= next_frac;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `WORD_RESET;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TCC_ADDR: reg_rdata_o <= {freq_hold, 8'h00, cmd_step, step_dir, cmd_read,
          cmd_load, cont_en, clock_en, cmd_reset};
        `PHASE_ADDR: reg_rdata_o <= {13'h0000, t_phase};
        `NS_HI_ADDR: reg_rdata_o <= t_ns[31:16];
        `NS_LO_ADDR: reg_rdata_o <= t_ns[15:0];
        `SEC_HI_ADDR: reg_rdata_o <= t_sec[31:16];
        `SEC_LO_ADDR: reg_rdata_o <= t_sec[15:0];
        `RATE_HI_ADDR: reg_rdata_o <= {rate_sign_select, rate_temp,
          fractional_rate_value[29:16]};
        `RATE_LO_ADDR: reg_rdata_o <= fractional_rate_value[15:0];
        default: reg_rdata_o <= `WORD_RESET;
      endcase
    end
  end

endmodule // ptp_clock_control

`default_nettype wire

// *** core/ptp_clock_defines.vh ***
`ifndef PTP_CLOCK_DEFINES_VH
`define PTP_CLOCK_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TCC_ADDR 16'h0500
`define PHASE_ADDR 16'h0502
`define NS_HI_ADDR 16'h0504
`define NS_LO_ADDR 16'h0506
`define SEC_HI_ADDR 16'h0508
`define SEC_LO_ADDR 16'h050a
`define RATE_HI_ADDR 16'h050c
`define RATE_LO_ADDR 16'h050e

// ****************************************************************
// Control register fields
// ****************************************************************
`define TCC_FREQ_HOLD_BIT 15
`define TCC_STEP_BIT 6
`define TCC_STEP_DIR_BIT 5
`define TCC_READ_BIT 4
`define TCC_LOAD_BIT 3
`define TCC_CONT_BIT 2
`define TCC_ENABLE_BIT 1
`define TCC_RESET_BIT 0

// ****************************************************************
// Rate high word fields
// ****************************************************************
`define RATE_SIGN_BIT 15
`define RATE_TEMP_BIT 14
`define RATE_HI_MSB 13

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define PHASE_RESET 3'h0
`define PHASE_MAX 3'h4
`define WORD_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 40
`define TICK_DIV 4'h4
`define NS_PER_TICK 33'h000000028
`define NS_PER_SEC 33'h03b9aca00
`define NS_WRAP 32'h3b9aca00

`endif

// *** core/tick_divider.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ptp_clock_defines.vh"

// ****************************************************************
// Divides the system clock down to the 25MHz time base pulse
// ****************************************************************
module tick_divider #(
  parameter [3:0] DIV = `TICK_DIV
) (
  input wire clock_i,
  input wire rst_n_i,
  output reg tick_o
);

  reg [3:0] count;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 4'h0;
      tick_o <= 1'b0;
    end else if (count == DIV - 4'h1) begin
      count <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      count <= count + 4'h1;
      tick_o <= 1'b0;
    end
  end

endmodule // tick_divider

`default_nettype wire

// *** test/ptp_clock_control_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ptp_clock_defines.vh"
// ****
// Port checker
// ****
module ptp_clock_control_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [2:0] rtc_phase_o,
  input wire logic [31:0] rtc_ns_o,
  input wire logic [31:0] rtc_sec_o,
  input wire logic switch_adj_pulse_o,
  input wire logic switch_adj_up_o
);
  // Control bits are not ports, so they are shadowed from the writes.
  logic wr_d1, wr_d2, en, hold, sign;
  wire logic cw = reg_wr_i && reg_addr_i == `TCC_ADDR;
  wire logic rc = reg_rd_i && reg_addr_i == `TCC_ADDR && !wr_d1 && !reg_wr_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {wr_d1, wr_d2, en, hold, sign} <= 5'h0;
    end else begin
      wr_d1 <= reg_wr_i;
      wr_d2 <= wr_d1;
      if (cw) {hold, en} <= {reg_wdata_i[15], reg_wdata_i[1]};
      if (reg_wr_i && reg_addr_i == `RATE_HI_ADDR) sign <= reg_wdata_i[15];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_PHASE_VALID: assert property (rtc_phase_o <= 3'h4)
    else $error("phase out of range");
  AST_NS_RANGE: assert property (rtc_ns_o < 32'h3b9aca00)
    else $error("nanoseconds out of range");
  AST_FROZEN: assert property (!en && !wr_d1 |=> $stable(rtc_ns_o))
    else $error("clock moved while stopped");
  AST_ADVANCE: assert property ((en && !wr_d1)[*4] |=> rtc_ns_o != $past(rtc_ns_o, 4))
    else $error("clock did not advance");
  AST_CTRL_SC: assert property (rc |=> (reg_rdata_o & 16'h7fd9) == 16'h0)
    else $error("command or reserved bit read as one");
  AST_READBACK: assert property (rc |=> reg_rdata_o[15] == hold && reg_rdata_o[1] == en)
    else $error("control bits read back wrong");
  AST_HOLD: assert property (hold && !wr_d1 |-> !switch_adj_pulse_o)
    else $error("correction passed to switch while held");
  AST_UP_SIGN: assert property (switch_adj_pulse_o && !wr_d1 && !wr_d2 |-> switch_adj_up_o == sign)
    else $error("correction sign wrong");
  AST_RESET_CMD: assert property (cw && reg_wdata_i[0] |-> ##2 rtc_ns_o == 0 && rtc_sec_o == 0)
    else $error("reset command did not clear time");
  cover property (switch_adj_pulse_o);
  cover property (cw && reg_wdata_i[6]);
  cover property (cw && reg_wdata_i[4]);
endmodule // ptp_clock_control_checker
bind ptp_clock_control ptp_clock_control_checker chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rtc_phase_o(rtc_phase_o), .rtc_ns_o(rtc_ns_o),
  .rtc_sec_o(rtc_sec_o), .switch_adj_pulse_o(switch_adj_pulse_o),
  .switch_adj_up_o(switch_adj_up_o));
`default_nettype wire

// *** test/ptp_clock_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ptp_clock_defines.vh"
// ****
// Bench
// ****
module ptp_clock_control_test;
  logic clock_i, rst_n_i, reg_wr_i, reg_rd_i;
  logic [15:0] reg_addr_i, reg_wdata_i;
  wire [15:0] reg_rdata_o;
  wire [2:0] rtc_phase_o;
  wire [31:0] rtc_ns_o, rtc_sec_o;
  wire switch_adj_pulse_o, switch_adj_up_o;
  int error_cnt = 0, check_count = 0, cycles = 0, pulses = 0, ups = 0;
  logic [31:0] d, n;
  ptp_clock_control uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rtc_phase_o(rtc_phase_o), .rtc_ns_o(rtc_ns_o),
    .rtc_sec_o(rtc_sec_o), .switch_adj_pulse_o(switch_adj_pulse_o),
    .switch_adj_up_o(switch_adj_up_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Corrections seen by the switch are counted here, the upward ones apart.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (switch_adj_pulse_o === 1'b1) pulses <= pulses + 1;
    if (switch_adj_pulse_o === 1'b1 && switch_adj_up_o === 1'b1) ups <= ups + 1;
    if (cycles == 4000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    #1 d = {16'h0, reg_rdata_o};
  endtask
  task automatic t_regs;
    for (int a = 16'h0500; a <= 16'h0510; a += 2) begin
      rd(a[15:0]);
      chk(d, 32'h0, "reset value");
    end
    $display("register test done");
  endtask
  task automatic t_load;
    wr(`PHASE_ADDR, 16'h0003);
    wr(`NS_LO_ADDR, 16'h01f4);
    wr(`SEC_HI_ADDR, 16'h0001);
    wr(`SEC_LO_ADDR, 16'h0007);
    wr(`TCC_ADDR, 16'h0008);
    repeat (3) @(posedge clock_i);
    #1 chk(rtc_ns_o, 32'h1f4, "load ns");
    chk(rtc_sec_o, 32'h10007, "load sec");
    chk({29'h0, rtc_phase_o}, 32'h3, "load phase");
    wr(`PHASE_ADDR, 16'h0005);
    rd(`PHASE_ADDR);
    chk(d, 32'h3, "bad phase taken");
    $display("load test done");
  endtask
  task automatic t_step;
    wr(`NS_LO_ADDR, 16'h0064);
    wr(`SEC_HI_ADDR, 16'h0000);
    wr(`SEC_LO_ADDR, 16'h0002);
    wr(`TCC_ADDR, 16'h0060);
    repeat (3) @(posedge clock_i);
    #1 chk(rtc_ns_o, 32'h258, "step add ns");
    chk(rtc_sec_o, 32'h10009, "step add sec");
    wr(`TCC_ADDR, 16'h0040);
    rd(`TCC_ADDR);
    chk(d, 32'h0, "step bit stuck");
    chk(rtc_ns_o, 32'h1f4, "step sub ns");
    chk(rtc_sec_o, 32'h10007, "step sub sec");
    $display("step test done");
  endtask
  task automatic t_capture;
    wr(`TCC_ADDR, 16'h0010);
    rd(`NS_LO_ADDR);
    chk(d, 32'h1f4, "capture ns");
    rd(`SEC_HI_ADDR);
    chk(d, 32'h1, "capture sec hi");
    rd(`SEC_LO_ADDR);
    chk(d, 32'h7, "capture sec lo");
    $display("capture test done");
  endtask
  // A half-nanosecond rate gives one carry every second tick from a cleared accumulator.
  task automatic t_rate(input logic hold, input logic up);
    int p, u;
    logic [31:0] c;
    wr(`TCC_ADDR, 16'h0001);
    repeat (2) @(posedge clock_i);
    #1 chk(rtc_ns_o, 32'h0, "reset cmd");
    chk(rtc_sec_o, 32'h0, "reset cmd sec");
    wr(`RATE_HI_ADDR, {up, 15'h2000});
    wr(`RATE_LO_ADDR, 16'h0000);
    p = pulses;
    u = ups;
    wr(`TCC_ADDR, {hold, 15'h0006});
    repeat (200) @(posedge clock_i);
    wr(`TCC_ADDR, {hold, 15'h0000});
    repeat (4) @(posedge clock_i);
    #1 n = rtc_ns_o;
    c = up ? n % 32'h28 : 32'h28 - n % 32'h28;
    chk(c, up ? (n / 32'h28) / 32'h2 : (n / 32'h28 + 32'h2) / 32'h2, "rate corrections");
    chk(pulses - p, hold ? 32'h0 : c, "switch pulses");
    chk(ups - u, (hold || !up) ? 32'h0 : c, "switch pulse sign");
    repeat (12) @(posedge clock_i);
    #1 chk(rtc_ns_o, n, "stopped clock moved");
    $display("rate test done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 16'h0000;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_load;
    t_step;
    t_capture;
    t_rate(1'b0, 1'b1);
    t_rate(1'b1, 1'b0);
    t_rate(1'b0, 1'b0);
    print_verdict;
  end
endmodule // ptp_clock_control_test
`default_nettype wire
